// ### rtl/pwmadf_top.sv
// PWM generator back end: event actions, dead-band, fault handling and output stage
`timescale 1ns/1ps

// Behaviour
// - Down mode: zero, load, A-down, B-down events
// - Up/down mode: six events incl. up matches
// - Matches coinciding with zero/load skip output actions
// - First output uses A match, second B
// - Per event action: none, toggle, low, high
// - Dead-band off: generated signals pass unchanged
// - Dead-band on: first output rising-edge delayed
// - Second output inverted, rising edge delayed
// - Selected events raise generator interrupt
// - Selected events emit ADC trigger pulse
// - Interrupt and trigger use raw events
// - Global synchronous reset of chosen counters
// - Immediate update takes effect at zero
// - Sync update waits for request, then zero
// - Update mode chosen per generator
// - Fault pin is the only fault; debug halt is not one
// - Fault forces enabled outputs inactive
// - Active fault can raise an interrupt
// - Debug halt: run on or stop at zero
// - Debug halt never raises an interrupt
// - One enable word gates outputs to pins
// - Optional per-output inversion to active low
// - Counter gives direction, zero and load pulses
// - Compare above load never matches
module pwmadf_top #(
  parameter int NGEN = 3
) (
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  input  wire pwmadf_pkg::pwmadf_gen_cfg_t [NGEN-1:0] gen_cfg,
  input  wire logic                                  upd_req,
  input  wire logic [NGEN-1:0]                       sync_rst,
  input  wire logic [2*NGEN-1:0]                     out_en,
  input  wire logic [2*NGEN-1:0]                     out_inv,
  input  wire logic [2*NGEN-1:0]                     fault_en,
  input  wire logic                                  fault_int_en,
  input  wire logic                                  debug_halt,
  input  wire logic                                  fault_pin,
  output logic      [2*NGEN-1:0]                     pwm_pin,
  output logic                                       fault_intr,
  output pwmadf_pkg::pwmadf_gen_stat_t [NGEN-1:0]    gen_stat
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pwmadf_pkg::pwmadf_gen_st_t [NGEN-1:0] gen;
    logic                                  fault_s1;
    logic                                  fault_s2;
    logic [2*NGEN-1:0]                     pin;
    logic                                  fault_intr;
  } pwmadf_state_t;

  pwmadf_state_t state_q;
  pwmadf_state_t state_d;

  logic [pwmadf_pkg::NUM_EVT-1:0] evt      [NGEN];
  logic [NGEN-1:0]                db_first;
  logic [NGEN-1:0]                db_second;

  // Applies one action code to the present output level
  function automatic logic act_apply(input logic cur, input logic [1:0] code);
    logic r;
    r = cur;
    unique case (code)
      pwmadf_pkg::ACT_NONE: r = cur;
      pwmadf_pkg::ACT_TOG:  r = ~cur;
      pwmadf_pkg::ACT_LOW:  r = 1'b0;
      pwmadf_pkg::ACT_HIGH: r = 1'b1;
    endcase
    return r;
  endfunction : act_apply

  // ----------------------------------------------------------------
  // Per-generator event decode and dead-band shaping
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NGEN; g++) begin : g_evt
    logic act;
    logic zero_p;
    logic load_p;
    logic ma;
    logic mb;

    // Frozen generators give no events at all
    assign act    = gen_cfg[g].run & ~state_q.gen[g].stall;
    assign zero_p = act & (state_q.gen[g].cnt == pwmadf_pkg::CNT_RST);
    assign load_p = act & (state_q.gen[g].cnt == state_q.gen[g].ld_act);
    // Compare above load is masked off so it can never fire
    assign ma = act & (state_q.gen[g].cnt == state_q.gen[g].ca_act)
              & (state_q.gen[g].ca_act <= state_q.gen[g].ld_act);
    assign mb = act & (state_q.gen[g].cnt == state_q.gen[g].cb_act)
              & (state_q.gen[g].cb_act <= state_q.gen[g].ld_act);

    // Direction qualifies matches; dir stays low in down mode
    assign evt[g][pwmadf_pkg::EV_ZERO] = zero_p;
    assign evt[g][pwmadf_pkg::EV_LOAD] = load_p;
    assign evt[g][pwmadf_pkg::EV_AUP]  = ma & state_q.gen[g].dir;
    assign evt[g][pwmadf_pkg::EV_ADN]  = ma & ~state_q.gen[g].dir;
    assign evt[g][pwmadf_pkg::EV_BUP]  = mb & state_q.gen[g].dir;
    assign evt[g][pwmadf_pkg::EV_BDN]  = mb & ~state_q.gen[g].dir;

    // Rising edge held back until the delay count is reached
    assign db_first[g]  = state_q.gen[g].gen_out_first
                        & (state_q.gen[g].rcnt >= gen_cfg[g].db_rise);
    // Inverse of the first signal, high only after the fall delay
    assign db_second[g] = ~state_q.gen[g].gen_out_first
                        & (state_q.gen[g].fcnt >= gen_cfg[g].db_fall);
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [pwmadf_pkg::NUM_EVT-1:0] ev_a;
    logic [pwmadf_pkg::NUM_EVT-1:0] ev_b;
    logic                           zl;
    logic                           apply_ld;
    logic                           apply_ca;
    logic                           apply_cb;
    logic [pwmadf_pkg::CNT_W-1:0]   ld_n;
    logic                           va;
    logic                           vb;
    logic                           ra;
    logic                           rb;
    logic                           fa;
    logic                           fb;
    ev_a     = '0;
    ev_b     = '0;
    zl       = 1'b0;
    apply_ld = 1'b0;
    apply_ca = 1'b0;
    apply_cb = 1'b0;
    ld_n     = '0;
    va       = 1'b0;
    vb       = 1'b0;
    ra       = 1'b0;
    rb       = 1'b0;
    fa       = 1'b0;
    fb       = 1'b0;
    state_d  = state_q;

    // Fault pin comes from outside; two flops before use
    state_d.fault_s1 = fault_pin;
    state_d.fault_s2 = state_q.fault_s1;
    // Debug halt is deliberately left out of this term
    state_d.fault_intr = state_q.fault_s2 & fault_int_en;

    for (int g = 0; g < NGEN; g++) begin
      // Pending value updates, applied only on a zero event
      zl       = evt[g][pwmadf_pkg::EV_ZERO] | evt[g][pwmadf_pkg::EV_LOAD];
      apply_ld = evt[g][pwmadf_pkg::EV_ZERO] & state_q.gen[g].ld_pend
               & (~gen_cfg[g].sync_load | state_q.gen[g].arm);
      apply_ca = evt[g][pwmadf_pkg::EV_ZERO] & state_q.gen[g].ca_pend
               & (~gen_cfg[g].sync_cmp | state_q.gen[g].arm);
      apply_cb = evt[g][pwmadf_pkg::EV_ZERO] & state_q.gen[g].cb_pend
               & (~gen_cfg[g].sync_cmp | state_q.gen[g].arm);
      ld_n = apply_ld ? state_q.gen[g].ld_sh : state_q.gen[g].ld_act;
      state_d.gen[g].ld_act = ld_n;
      if (apply_ld) begin
        state_d.gen[g].ld_pend = 1'b0;
      end
      if (apply_ca) begin
        state_d.gen[g].ca_act  = state_q.gen[g].ca_sh;
        state_d.gen[g].ca_pend = 1'b0;
      end
      if (apply_cb) begin
        state_d.gen[g].cb_act  = state_q.gen[g].cb_sh;
        state_d.gen[g].cb_pend = 1'b0;
      end
      // Arm is spent on the next zero event, whether or not that event applies anything
      if (evt[g][pwmadf_pkg::EV_ZERO]) begin
        state_d.gen[g].arm = 1'b0;
      end
      if (upd_req) begin
        state_d.gen[g].arm = 1'b1;
      end
      // A write in the same cycle as an apply stays pending
      if (gen_cfg[g].load_wr) begin
        state_d.gen[g].ld_sh   = gen_cfg[g].load_val;
        state_d.gen[g].ld_pend = 1'b1;
      end
      if (gen_cfg[g].cmpa_wr) begin
        state_d.gen[g].ca_sh   = gen_cfg[g].cmpa_val;
        state_d.gen[g].ca_pend = 1'b1;
      end
      if (gen_cfg[g].cmpb_wr) begin
        state_d.gen[g].cb_sh   = gen_cfg[g].cmpb_val;
        state_d.gen[g].cb_pend = 1'b1;
      end

      // Counter walk; counting up, a count at or above the load turns down at load minus one
      if (gen_cfg[g].run && !state_q.gen[g].stall) begin
        if (!gen_cfg[g].updown) begin
          state_d.gen[g].dir = 1'b0;
          if (evt[g][pwmadf_pkg::EV_ZERO]) begin
            state_d.gen[g].cnt = ld_n;
          end else begin
            state_d.gen[g].cnt = state_q.gen[g].cnt - pwmadf_pkg::CNT_ONE;
          end
        end else if (state_q.gen[g].dir) begin
          if (state_q.gen[g].cnt >= ld_n) begin
            state_d.gen[g].dir = 1'b0;
            state_d.gen[g].cnt = (ld_n == pwmadf_pkg::CNT_RST) ? ld_n
                                 : ld_n - pwmadf_pkg::CNT_ONE;
          end else begin
            state_d.gen[g].cnt = state_q.gen[g].cnt + pwmadf_pkg::CNT_ONE;
          end
        end else begin
          if (state_q.gen[g].cnt == pwmadf_pkg::CNT_RST) begin
            state_d.gen[g].dir = 1'b1;
            state_d.gen[g].cnt = (ld_n == pwmadf_pkg::CNT_RST) ? ld_n
                                 : pwmadf_pkg::CNT_ONE;
          end else begin
            state_d.gen[g].cnt = state_q.gen[g].cnt - pwmadf_pkg::CNT_ONE;
          end
        end
      end

      // Debug halt: stop once zero is reached, resume on release
      if (!debug_halt || !gen_cfg[g].stop_on_halt) begin
        state_d.gen[g].stall = 1'b0;
      end else if (evt[g][pwmadf_pkg::EV_ZERO]) begin
        state_d.gen[g].stall = 1'b1;
        state_d.gen[g].cnt   = pwmadf_pkg::CNT_RST;
      end

      // Global sync reset wins over the walk
      if (sync_rst[g]) begin
        state_d.gen[g].cnt = pwmadf_pkg::CNT_RST;
        state_d.gen[g].dir = 1'b0;
      end

      // Output actions, zero first then load then matches
      ev_a = evt[g] & pwmadf_pkg::EVT_A_MASK;
      ev_b = evt[g] & pwmadf_pkg::EVT_B_MASK;
      if (zl) begin
        ev_a = ev_a & ~pwmadf_pkg::EVT_MATCH_MASK;
        ev_b = ev_b & ~pwmadf_pkg::EVT_MATCH_MASK;
      end
      va = state_q.gen[g].gen_out_first;
      vb = state_q.gen[g].gen_out_second;
      for (int e = 0; e < pwmadf_pkg::NUM_EVT; e++) begin
        if (ev_a[e]) begin
          va = act_apply(va, gen_cfg[g].act_a[2*e +: 2]);
        end
        if (ev_b[e]) begin
          vb = act_apply(vb, gen_cfg[g].act_b[2*e +: 2]);
        end
      end
      state_d.gen[g].gen_out_first  = va;
      state_d.gen[g].gen_out_second = vb;

      // Dead-band delay counters saturate at the programmed delay
      if (!state_q.gen[g].gen_out_first) begin
        state_d.gen[g].rcnt = pwmadf_pkg::DB_RST;
      end else if (state_q.gen[g].rcnt < gen_cfg[g].db_rise) begin
        state_d.gen[g].rcnt = state_q.gen[g].rcnt + pwmadf_pkg::DB_ONE;
      end
      if (state_q.gen[g].gen_out_first) begin
        state_d.gen[g].fcnt = pwmadf_pkg::DB_RST;
      end else if (state_q.gen[g].fcnt < gen_cfg[g].db_fall) begin
        state_d.gen[g].fcnt = state_q.gen[g].fcnt + pwmadf_pkg::DB_ONE;
      end

      // Raw events drive interrupt and trigger, not shaped edges
      state_d.gen[g].intr = |(evt[g] & gen_cfg[g].int_sel);
      state_d.gen[g].trig = |(evt[g] & gen_cfg[g].trig_sel);

      // Output stage: select, fault force, invert, enable
      ra = gen_cfg[g].db_en ? db_first[g]  : state_q.gen[g].gen_out_first;
      rb = gen_cfg[g].db_en ? db_second[g] : state_q.gen[g].gen_out_second;
      // Forcing before inversion keeps inverted pins inactive too
      fa = ra & ~(state_q.fault_s2 & fault_en[2*g]);
      fb = rb & ~(state_q.fault_s2 & fault_en[2*g+1]);
      state_d.pin[2*g]   = out_en[2*g]   & (fa ^ out_inv[2*g]);
      state_d.pin[2*g+1] = out_en[2*g+1] & (fb ^ out_inv[2*g+1]);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from state flops
  // ----------------------------------------------------------------
  assign pwm_pin    = state_q.pin;
  assign fault_intr = state_q.fault_intr;
  for (genvar g = 0; g < NGEN; g++) begin : g_stat
    assign gen_stat[g].count    = state_q.gen[g].cnt;
    assign gen_stat[g].dir      = state_q.gen[g].dir;
    assign gen_stat[g].stalled  = state_q.gen[g].stall;
    assign gen_stat[g].intr     = state_q.gen[g].intr;
    assign gen_stat[g].adc_trig = state_q.gen[g].trig;
  end

endmodule : pwmadf_top

// ### rtl/pwmadf_pkg.sv
// Shared constants and carrier types for the PWM action, dead-band and output block
package pwmadf_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int CNT_W   = 16;  // Counter, load and compare width
  localparam int DB_W    = 12;  // Dead-band delay count width
  localparam int NUM_EVT = 6;   // Counter events per generator

  // ----------------------------------------------------------------
  // Event bit positions
  // ----------------------------------------------------------------
  localparam int EV_ZERO = 0;
  localparam int EV_LOAD = 1;
  localparam int EV_AUP  = 2;
  localparam int EV_ADN  = 3;
  localparam int EV_BUP  = 4;
  localparam int EV_BDN  = 5;

  // Events each output listens to, and the match events
  localparam logic [NUM_EVT-1:0] EVT_A_MASK     = 6'h0F;
  localparam logic [NUM_EVT-1:0] EVT_B_MASK     = 6'h33;
  localparam logic [NUM_EVT-1:0] EVT_MATCH_MASK = 6'h3C;

  // ----------------------------------------------------------------
  // Per-event action codes, two bits per event
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOG  = 2'h1;
  localparam logic [1:0] ACT_LOW  = 2'h2;
  localparam logic [1:0] ACT_HIGH = 2'h3;

  // ----------------------------------------------------------------
  // Reset and step values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [DB_W-1:0]  DB_RST  = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [DB_W-1:0]  DB_ONE  = 12'h001;

  // ----------------------------------------------------------------
  // Per-generator configuration, driven by the control logic
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                   run;          // Counter enable
    logic                   updown;       // 1: up/down, 0: down only
    logic                   sync_load;    // Load value waits for global update
    logic                   sync_cmp;     // Compare values wait for global update
    logic                   stop_on_halt; // Stop at zero during debug halt
    logic                   db_en;        // Dead-band pair mode
    logic [CNT_W-1:0]       load_val;
    logic                   load_wr;      // One-cycle write strobe
    logic [CNT_W-1:0]       cmpa_val;
    logic                   cmpa_wr;
    logic [CNT_W-1:0]       cmpb_val;
    logic                   cmpb_wr;
    logic [2*NUM_EVT-1:0]   act_a;        // Actions for first output
    logic [2*NUM_EVT-1:0]   act_b;        // Actions for second output
    logic [DB_W-1:0]        db_rise;
    logic [DB_W-1:0]        db_fall;
    logic [NUM_EVT-1:0]     int_sel;
    logic [NUM_EVT-1:0]     trig_sel;
  } pwmadf_gen_cfg_t;

  // ----------------------------------------------------------------
  // Per-generator status seen outside
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             dir;       // 1 while counting up
    logic             stalled;   // Stopped by debug halt
    logic             intr;      // One-cycle interrupt pulse
    logic             adc_trig;  // One-cycle trigger pulse
  } pwmadf_gen_stat_t;

  // ----------------------------------------------------------------
  // Per-generator internal state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             dir;
    logic             stall;
    logic [CNT_W-1:0] ld_act;
    logic [CNT_W-1:0] ca_act;
    logic [CNT_W-1:0] cb_act;
    logic [CNT_W-1:0] ld_sh;
    logic [CNT_W-1:0] ca_sh;
    logic [CNT_W-1:0] cb_sh;
    logic             ld_pend;
    logic             ca_pend;
    logic             cb_pend;
    logic             arm;
    logic             gen_out_first;
    logic             gen_out_second;
    logic [DB_W-1:0]  rcnt;
    logic [DB_W-1:0]  fcnt;
    logic             intr;
    logic             trig;
  } pwmadf_gen_st_t;

endpackage : pwmadf_pkg

// ### dv/pwmadf_monitor.sv
// Port-level assertions for the PWM back end
`timescale 1ns/1ps
module pwmadf_monitor #(
  parameter int NGEN = 3
) (
  input wire logic                                   clk,
  input wire logic                                   rst_n,
  input wire pwmadf_pkg::pwmadf_gen_cfg_t [NGEN-1:0]  gen_cfg,
  input wire logic [NGEN-1:0]                        sync_rst,
  input wire logic [2*NGEN-1:0]                      out_en,
  input wire logic [2*NGEN-1:0]                      out_inv,
  input wire logic [2*NGEN-1:0]                      fault_en,
  input wire logic                                   fault_int_en,
  input wire logic                                   debug_halt,
  input wire logic                                   fault_pin,
  input wire logic [2*NGEN-1:0]                      pwm_pin,
  input wire logic                                   fault_intr,
  input wire pwmadf_pkg::pwmadf_gen_stat_t [NGEN-1:0] gen_stat
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Fault path is two sync flops plus the output register
  a_fault_intr_on: assert property ((fault_pin && fault_int_en)[*3] |=> fault_intr)
    else $error("fault interrupt missing");
  a_no_halt_intr: assert property ((!fault_pin)[*3] |=> !fault_intr)
    else $error("interrupt without fault");
  // Forced level lands before inversion
  a_fault_force: assert property (fault_pin[*3] |=>
    ((pwm_pin ^ ($past(out_en) & $past(out_inv))) & $past(fault_en)) == '0)
    else $error("faulted pin not at inactive level");
  a_disabled_low: assert property (1'b1 |=> (pwm_pin & ~$past(out_en)) == '0)
    else $error("disabled pin driven");
  a_sync_clear: assert property (sync_rst[0] |-> ##[1:2] gen_stat[0].count == '0)
    else $error("counter not cleared by sync reset");
  a_stall_zero: assert property (gen_stat[0].stalled |-> gen_stat[0].count == '0)
    else $error("stalled away from zero");
  a_stall_quiet: assert property ((gen_stat[0].stalled && debug_halt
    && gen_cfg[0].stop_on_halt)[*2] |-> !gen_stat[0].intr && !gen_stat[0].adc_trig)
    else $error("events while stalled");
  a_halt_ignored: assert property ((!gen_cfg[0].stop_on_halt)[*2] |->
    !gen_stat[0].stalled)
    else $error("stall without stop option");

  c_stall: cover property (gen_stat[0].stalled);
  c_fault: cover property (fault_intr);
  c_sync: cover property (sync_rst[0]);
endmodule : pwmadf_monitor

// ### dv/pwmadf_gate_model.sv
// Gate-driver stand-in: counts cycles with both switches of leg 0 on
`timescale 1ns/1ps
module pwmadf_gate_model #(
  parameter int NGEN = 3
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [2*NGEN-1:0] gate,
  output logic      [15:0]       shoot_cnt
);
  // Both on would short the supply; the bench only judges this in pair mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shoot_cnt <= 16'h0000;
    end else if (gate[0] && gate[1]) begin
      shoot_cnt <= shoot_cnt + 16'h0001;
    end
  end
endmodule : pwmadf_gate_model

// ### dv/pwmadf_tb_top.sv
// Self-checking bench for the PWM back end
`timescale 1ns/1ps
module pwmadf_tb_top;
  localparam int NG = 3;
  pwmadf_pkg::pwmadf_gen_cfg_t  [NG-1:0] cfg;
  pwmadf_pkg::pwmadf_gen_stat_t [NG-1:0] st;
  logic [NG-1:0]   sync_rst;
  logic [2*NG-1:0] out_en, out_inv, fault_en, pwm_pin;
  logic            clk, rst_n, upd_req, fault_int_en, debug_halt, fault_pin, fault_intr;
  logic [15:0]     shoot_cnt, s0;
  int              fail_count, tests_run, cyc, ic, tc;
  int              hc[2*NG];

  pwmadf_top #(.NGEN(NG)) pwmadf_top_i (.clk(clk), .rst_n(rst_n), .gen_cfg(cfg),
    .upd_req(upd_req), .sync_rst(sync_rst), .out_en(out_en), .out_inv(out_inv),
    .fault_en(fault_en), .fault_int_en(fault_int_en), .debug_halt(debug_halt),
    .fault_pin(fault_pin), .pwm_pin(pwm_pin), .fault_intr(fault_intr), .gen_stat(st));
  pwmadf_gate_model #(.NGEN(NG)) pwmadf_gate_model_i (.clk(clk), .rst_n(rst_n),
    .gate(pwm_pin), .shoot_cnt(shoot_cnt));

  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      summarize();
    end
  end

  // Helpers: action words, waits, compare, pulse counting
  function automatic logic [11:0] act(int e, logic [1:0] c);
    return 12'(c) << (2 * e);
  endfunction : act
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task automatic count_hi(input int w);
    hc = '{default: 0};
    ic = 0;
    tc = 0;
    repeat (w) begin
      @(negedge clk);
      for (int i = 0; i < 2*NG; i++) hc[i] += (pwm_pin[i] === 1'b1);
      ic += (st[0].intr === 1'b1);
      tc += (st[0].adc_trig === 1'b1);
      // Counting with === would hide unknown pins, so flag them
      chk(32'($isunknown(pwm_pin)), 32'h0);
    end
  endtask : count_hi
  // Write load and compares with one-cycle strobes, set actions
  task automatic prog(input int g, input logic [15:0] l, a, b, input logic [11:0] xa, xb);
    @(negedge clk);
    cfg[g].run = 1'b1;
    cfg[g].load_val = l;
    cfg[g].cmpa_val = a;
    cfg[g].cmpb_val = b;
    cfg[g].act_a = xa;
    cfg[g].act_b = xb;
    {cfg[g].load_wr, cfg[g].cmpa_wr, cfg[g].cmpb_wr} = 3'h7;
    @(negedge clk);
    {cfg[g].load_wr, cfg[g].cmpa_wr, cfg[g].cmpb_wr} = 3'h0;
  endtask : prog
  task automatic srst(input logic [NG-1:0] m);
    sync_rst = m;
    tick(1);
    sync_rst = 3'h0;
  endtask : srst

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Down mode, passthrough, toggle, discarded matches, enables
  task automatic t_down();
    prog(0, 16'h9, 16'h4, 16'h7, act(0, 2'h3) | act(3, 2'h2), act(0, 2'h3) | act(5, 2'h2));
    prog(1, 16'h9, 16'h0, 16'h0, act(0, 2'h1), act(0, 2'h3));
    prog(2, 16'h9, 16'h0, 16'h9, act(3, 2'h1), act(5, 2'h1));
    out_en = 6'h37;
    out_inv = 6'h02;
    tick(30);
    count_hi(20);
    chk(hc[0], 32'hC);
    chk(hc[1], 32'hE);
    chk(hc[2], 32'hA);
    chk(hc[3], 32'h0);
    chk(hc[4], 32'h0);
    chk(hc[5], 32'h0);
    chk(32'(st[0].dir), 32'h0);
  endtask : t_down
  // Up/down with coinciding A and B matches, interrupt and trigger selection
  task automatic t_updown();
    prog(0, 16'h8, 16'h3, 16'h3, 12'hC96, 12'hC96);
    out_inv = 6'h00;
    cfg[0].updown = 1'b1;
    cfg[0].int_sel = 6'h04;
    cfg[0].trig_sel = 6'h03;
    srst(3'h1);
    tick(40);
    count_hi(32);
    // A: high from A-up to load toggle, 5 of 16; B: load toggle to zero, 8 of 16
    chk(hc[0], 32'hA);
    chk(hc[1], 32'h10);
    chk(ic, 32'h2);
    chk(tc, 32'h4);
  endtask : t_updown
  // Pair mode with rising and falling delays
  task automatic t_db();
    prog(0, 16'h9, 16'h4, 16'h7, act(0, 2'h3) | act(3, 2'h2), 12'h000);
    cfg[0].updown = 1'b0;
    cfg[0].db_en = 1'b1;
    cfg[0].db_rise = 12'h002;
    cfg[0].db_fall = 12'h003;
    cfg[0].int_sel = 6'h01;
    cfg[0].trig_sel = 6'h08;
    srst(3'h1);
    tick(30);
    s0 = shoot_cnt;
    count_hi(20);
    chk(hc[0], 32'h8);
    chk(hc[1], 32'h2);
    chk(32'(shoot_cnt), 32'(s0));
    chk(ic, 32'h2);
    chk(tc, 32'h2);
  endtask : t_db
  // Compare held back until the global update, then taken at zero
  task automatic t_sync();
    cfg[0].db_en = 1'b0;
    cfg[0].sync_load = 1'b1;
    cfg[0].sync_cmp = 1'b1;
    prog(0, 16'h7, 16'h3, 16'h3, act(0, 2'h3) | act(3, 2'h2), act(0, 2'h3) | act(5, 2'h2));
    tick(30);
    count_hi(20);
    chk(hc[0], 32'hC);
    chk(hc[1], 32'h6);
    upd_req = 1'b1;
    tick(1);
    upd_req = 1'b0;
    tick(25);
    // New period of 8 with match at 3: high 5 of every 8
    count_hi(24);
    chk(hc[0], 32'hF);
    chk(hc[1], 32'hF);
  endtask : t_sync
  // Fault forcing on an inverted and a plain pin
  task automatic t_fault();
    out_inv = 6'h01;
    fault_en = 6'h05;
    fault_int_en = 1'b1;
    fault_pin = 1'b1;
    tick(5);
    count_hi(24);
    chk(hc[0], 32'h18);
    chk(hc[1], 32'hF);
    chk(hc[2], 32'h0);
    chk(32'(fault_intr), 32'h1);
    fault_pin = 1'b0;
    tick(5);
    chk(32'(fault_intr), 32'h0);
    out_inv = 6'h00;
    fault_en = 6'h00;
  endtask : t_fault
  // Counter alignment, then debug halt with and without stop
  task automatic t_halt();
    srst(3'h6);
    tick(2);
    chk(32'(st[1].count), 32'(st[2].count));
    chk(32'(st[1].count), 32'h8);
    cfg[0].stop_on_halt = 1'b1;
    cfg[0].int_sel = 6'h01;
    debug_halt = 1'b1;
    tick(12);
    chk(32'(st[0].stalled), 32'h1);
    chk(32'(st[0].count), 32'h0);
    count_hi(10);
    chk(ic, 32'h0);
    chk(32'(fault_intr), 32'h0);
    chk(32'(st[1].stalled), 32'h0);
    debug_halt = 1'b0;
    tick(3);
    chk(32'(st[0].stalled), 32'h0);
  endtask : t_halt

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // Reset for 16 cycles, then the scenarios in turn
  initial begin
    {cfg, sync_rst, out_en, out_inv, fault_en} = '0;
    {upd_req, fault_int_en, debug_halt, fault_pin, rst_n} = 5'h00;
    {fail_count, tests_run, cyc} = '0;
    tick(16);
    rst_n = 1'b1;
    t_down();
    t_updown();
    t_db();
    t_sync();
    t_fault();
    t_halt();
    summarize();
  end
endmodule : pwmadf_tb_top

bind pwmadf_top pwmadf_monitor #(.NGEN(NGEN)) pwmadf_monitor_i (.clk(clk), .rst_n(rst_n),
  .gen_cfg(gen_cfg), .sync_rst(sync_rst), .out_en(out_en), .out_inv(out_inv),
  .fault_en(fault_en), .fault_int_en(fault_int_en), .debug_halt(debug_halt),
  .fault_pin(fault_pin), .pwm_pin(pwm_pin), .fault_intr(fault_intr), .gen_stat(gen_stat));
